// >>> inc/wdrst_pkg.sv
// Constants and types shared by the watchdog and reset-source logic
package wdrst_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] RESET_CAUSE_ADDR = 8'hEF;
	localparam logic [7:0] WDOG_CTRL_ADDR   = 8'hB7;

	// ****************************************
	// Watchdog control codes and fields
	// ****************************************
	localparam logic [7:0] WDOG_CODE_ENABLE  = 8'hA5;
	localparam logic [7:0] WDOG_CODE_DISARM1 = 8'hDE;
	localparam logic [7:0] WDOG_CODE_DISARM2 = 8'hAD;
	localparam logic [7:0] WDOG_CODE_LOCK    = 8'hFF;
	localparam int         WDOG_WR_GUARD_BIT = 7;
	localparam int         WDOG_ACTIVE_BIT   = 4;
	localparam logic [2:0] WDOG_INTERVAL_RST = 3'h7;
	localparam logic [2:0] WDOG_DISARM_WIN   = 3'h4;
	localparam logic [4:0] WDOG_EXP_BASE     = 5'h06;
	localparam int         WDOG_COUNTER_W    = 21;

	// ****************************************
	// Reset cause register bit positions
	// ****************************************
	localparam int RC_PIN_BIT  = 0;
	localparam int RC_POR_BIT  = 1;
	localparam int RC_MCD_BIT  = 2;
	localparam int RC_WDOG_BIT = 3;
	localparam int RC_SW_BIT   = 4;
	localparam int RC_CMP_BIT  = 5;
	localparam int RC_CNV_BIT  = 6;
	localparam int RC_TEST_BIT = 7;
	localparam int RC_FLAGS_W  = 7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_FREQ_HZ     = 10_000_000;
	localparam int POR_HOLD_MS     = 100;
	localparam int POR_HOLD_MIN_MS = 80;
	localparam int POR_HOLD_MAX_MS = 120;
	localparam int POR_HOLD_CYCLES = POR_HOLD_MS * (CLK_FREQ_HZ / 1000);
	localparam int MCD_MIN_US      = 100;
	localparam int MCD_TYP_US      = 220;
	localparam int MCD_MAX_US      = 500;
	localparam int INT_HOLD_CYCLES = 12;

	// ****************************************
	// Reset sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		WDRST_RUN,
		WDRST_POR_HOLD,
		WDRST_INT_HOLD
	} wdrst_rst_state_t;

endpackage

// >>> inc/wdrst_wdog_if.sv
// Link between the reset controller and the watchdog counter
`timescale 1ns/1ps
interface wdrst_wdog_if;
	logic       enable;
	logic       restart;
	logic [2:0] interval;
	logic       overflow;

	modport ctrl (
		output enable,
		output restart,
		output interval,
		input  overflow
	);

	modport counter (
		input  enable,
		input  restart,
		input  interval,
		output overflow
	);
endinterface

// >>> core/wdrst_wdog_counter.sv
// Watchdog counter with power-of-four timeout
`timescale 1ns/1ps
module wdrst_wdog_counter
	import wdrst_pkg::*;
#(
	parameter int CNT_W = WDOG_COUNTER_W
)(
	input  wire logic     clk_i,
	input  wire logic     reset_n_i,
	wdrst_wdog_if.counter wd
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             ovf;
	} wdrst_cnt_state_t;

	wdrst_cnt_state_t s;
	wdrst_cnt_state_t next_s;
	logic [4:0]       shamt;
	logic [CNT_W-1:0] limit;

	// ****************************************
	// Terminal count: 4^(3+k) cycles
	// ****************************************
	assign shamt = {wd.interval, 1'b0} + WDOG_EXP_BASE;
	assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << shamt) - CNT_W'(1);

	always_comb begin
		next_s = s;
		next_s.ovf = 1'b0;
		if (wd.restart || !wd.enable) begin
			next_s.cnt = '0;
		end else if (s.cnt == limit) begin
			next_s.cnt = '0;
			next_s.ovf = 1'b1;
		end else begin
			next_s.cnt = s.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign wd.overflow = s.ovf;

endmodule

// >>> core/wdrst_top.sv
// Watchdog timer and reset-source controller, top level
//
// Overview of operation
// - Watchdog timeout is four to the power three plus interval field clocks.
// - Control register read returns the programmed interval in bits two to zero.
// - Interval field becomes all ones after every system reset.
// - Writing the enable code enables the watchdog and restarts its count.
// - Disable needs first code then second code within four clocks.
// - Writing the lock code blocks every later disable sequence until the next reset.
// - Control register bit four reads one while the watchdog runs.
// - Reset cause bit seven reads one while the test port is in reset.
// - Bit six enables convert-start reset; reads set after such a reset.
// - Bit five enables comparator reset; reads set after such a reset.
// - Bit four forces an internal reset without the pin; reads its flag.
// - Bit three reads one after a watchdog timeout reset.
// - Bit two reads one after a missing-clock detector reset.
// - Bit one forces a power-on reset driving the pin low; reads its flag.
// - Bit zero reads one after a reset from the external pin.
// - Pin held low about 100 ms after supply crosses threshold.
// - Missing-clock reset comes 100 to 500 us after the clock stops.
// - Watchdog is a 21-bit counter measuring time between restart writes.
// - Every reset exit starts the watchdog at maximum interval, unlocked.
// - Watchdog overflow forces an internal reset without driving the pin.
// - Lock code neither enables nor restarts; lock lasts until reset.
`timescale 1ns/1ps
module wdrst_top
	import wdrst_pkg::*;
#(
	parameter int POR_HOLD_COUNT = POR_HOLD_CYCLES,
	parameter int WDOG_CNT_W     = WDOG_COUNTER_W
)(
	input  wire logic       CLK_I,
	input  wire logic       RESET_N_I,
	input  wire logic       VDD_OK_I,
	input  wire logic       RST_PIN_I,
	output      logic       RST_PIN_O,
	output      logic       RST_PIN_OE_N_O,
	input  wire logic       CONVERT_START_INPUT_N_I,
	input  wire logic       COMPARATOR_OUT_I,
	input  wire logic       MISSING_CLOCK_REQ_I,
	input  wire logic       TEST_PORT_RESET_I,
	input  wire logic [7:0] SFR_ADDR_I,
	input  wire logic       SFR_WE_I,
	input  wire logic       SFR_RE_I,
	input  wire logic [7:0] SFR_WDATA_I,
	output      logic [7:0] SFR_RDATA_O,
	output      logic       SYS_RESET_N_O,
	output      logic       WDOG_ACTIVE_O
);

	// ****************************************
	// State
	// ****************************************
	localparam int HOLD_W = $clog2(POR_HOLD_COUNT + 1);

	typedef struct packed {
		wdrst_rst_state_t        rst_state;
		logic [HOLD_W-1:0]       hold_cnt;
		logic                    pin_drive;
		logic                    sys_run;
		logic [RC_FLAGS_W-1:0]   flags;
		logic                    cnv_en;
		logic                    cmp_en;
		logic                    wd_en;
		logic                    wd_lock;
		logic [2:0]              interval;
		logic [2:0]              disarm_win;
		logic [7:0]              rdata;
	} wdrst_top_state_t;

	localparam wdrst_top_state_t ST_RESET = '{
		rst_state:  WDRST_POR_HOLD,
		hold_cnt:   '0,
		pin_drive:  1'b1,
		sys_run:    1'b0,
		flags:      7'h02,
		cnv_en:     1'b0,
		cmp_en:     1'b0,
		wd_en:      1'b1,
		wd_lock:    1'b0,
		interval:   WDOG_INTERVAL_RST,
		disarm_win: 3'h0,
		rdata:      8'h00
	};

	wdrst_top_state_t s;
	wdrst_top_state_t next_s;

	logic                  run;
	logic                  pin_low;
	logic                  wr_wdog;
	logic                  wr_cause;
	logic [RC_FLAGS_W-1:0] cause;
	logic [7:0]            wdog_rd;
	logic [7:0]            cause_rd;

	wdrst_wdog_if wd ();

	// ****************************************
	// Watchdog counter
	// ****************************************
	wdrst_wdog_counter #(
		.CNT_W     (WDOG_CNT_W)
	) u_wdog_counter (
		.clk_i     (CLK_I),
		.reset_n_i (RESET_N_I),
		.wd        (wd)
	);

	assign wd.enable   = s.wd_en && s.sys_run;
	assign wd.interval = s.interval;
	// Held in restart through reset and on each enable code
	assign wd.restart  = !s.sys_run
		|| (wr_wdog && SFR_WDATA_I == WDOG_CODE_ENABLE);

	// ****************************************
	// Decode
	// ****************************************
	assign run      = (s.rst_state == WDRST_RUN) && s.sys_run;
	// Pin only counts as an outside reset while not driven by us
	assign pin_low  = !RST_PIN_I && !s.pin_drive;
	assign wr_wdog  = run && SFR_WE_I && (SFR_ADDR_I == WDOG_CTRL_ADDR);
	assign wr_cause = run && SFR_WE_I && (SFR_ADDR_I == RESET_CAUSE_ADDR);

	// ****************************************
	// Read values
	// ****************************************
	always_comb begin
		wdog_rd = 8'h00;
		wdog_rd[2:0] = s.interval;
		wdog_rd[WDOG_ACTIVE_BIT] = s.wd_en && s.sys_run;
	end

	always_comb begin
		cause_rd = {1'b0, s.flags};
		cause_rd[RC_TEST_BIT] = TEST_PORT_RESET_I;
	end

	// ****************************************
	// Reset source selection
	// ****************************************
	always_comb begin
		cause = '0;
		if (!VDD_OK_I) begin
			cause[RC_POR_BIT] = 1'b1;
		end else if (wr_cause && SFR_WDATA_I[RC_POR_BIT]) begin
			cause[RC_POR_BIT] = 1'b1;
		end else if (pin_low) begin
			cause[RC_PIN_BIT] = 1'b1;
		end else if (MISSING_CLOCK_REQ_I) begin
			cause[RC_MCD_BIT] = 1'b1;
		end else if (run && s.wd_en && wd.overflow) begin
			cause[RC_WDOG_BIT] = 1'b1;
		end else if (s.cnv_en && !CONVERT_START_INPUT_N_I) begin
			cause[RC_CNV_BIT] = 1'b1;
		end else if (s.cmp_en && !COMPARATOR_OUT_I) begin
			cause[RC_CMP_BIT] = 1'b1;
		end else if (wr_cause && SFR_WDATA_I[RC_SW_BIT]) begin
			cause[RC_SW_BIT] = 1'b1;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;

		// Register read port, one cycle latency
		if (SFR_RE_I) begin
			if (SFR_ADDR_I == WDOG_CTRL_ADDR) begin
				next_s.rdata = wdog_rd;
			end else if (SFR_ADDR_I == RESET_CAUSE_ADDR) begin
				next_s.rdata = cause_rd;
			end else begin
				next_s.rdata = 8'h00;
			end
		end

		// Disable window ages every clock
		if (s.disarm_win != 3'h0) begin
			next_s.disarm_win = s.disarm_win - 3'h1;
		end

		// Watchdog control writes
		if (wr_wdog) begin
			if (SFR_WDATA_I == WDOG_CODE_ENABLE) begin
				next_s.wd_en = 1'b1;
				next_s.disarm_win = 3'h0;
			end else if (SFR_WDATA_I == WDOG_CODE_DISARM1) begin
				next_s.disarm_win = WDOG_DISARM_WIN;
			end else if (SFR_WDATA_I == WDOG_CODE_DISARM2) begin
				if (s.disarm_win != 3'h0 && !s.wd_lock) begin
					next_s.wd_en = 1'b0;
				end
				next_s.disarm_win = 3'h0;
			end else if (SFR_WDATA_I == WDOG_CODE_LOCK) begin
				next_s.wd_lock = 1'b1;
				next_s.disarm_win = 3'h0;
			end else if (!SFR_WDATA_I[WDOG_WR_GUARD_BIT]) begin
				next_s.interval = SFR_WDATA_I[2:0];
				next_s.disarm_win = 3'h0;
			end else begin
				next_s.disarm_win = 3'h0;
			end
		end

		// Reset source enables
		if (wr_cause) begin
			next_s.cnv_en = SFR_WDATA_I[RC_CNV_BIT];
			next_s.cmp_en = SFR_WDATA_I[RC_CMP_BIT];
		end

		// Reset sequencer
		unique case (s.rst_state)
			WDRST_RUN: begin
				next_s.sys_run = 1'b1;
				next_s.pin_drive = 1'b0;
				if (cause[RC_POR_BIT]) begin
					next_s.rst_state = WDRST_POR_HOLD;
					next_s.hold_cnt = '0;
					next_s.pin_drive = 1'b1;
					next_s.sys_run = 1'b0;
					next_s.flags = cause;
				end else if (cause != '0) begin
					next_s.rst_state = WDRST_INT_HOLD;
					next_s.hold_cnt = HOLD_W'(INT_HOLD_CYCLES);
					next_s.sys_run = 1'b0;
					next_s.flags = cause;
				end
			end
			WDRST_POR_HOLD: begin
				next_s.pin_drive = 1'b1;
				next_s.sys_run = 1'b0;
				if (!VDD_OK_I) begin
					next_s.hold_cnt = '0;
				end else if (s.hold_cnt
					== HOLD_W'(POR_HOLD_COUNT - 1)) begin
					next_s.rst_state = WDRST_RUN;
					next_s.pin_drive = 1'b0;
				end else begin
					next_s.hold_cnt = s.hold_cnt + HOLD_W'(1);
				end
			end
			WDRST_INT_HOLD: begin
				next_s.pin_drive = 1'b0;
				next_s.sys_run = 1'b0;
				if (!VDD_OK_I) begin
					next_s.rst_state = WDRST_POR_HOLD;
					next_s.hold_cnt = '0;
					next_s.pin_drive = 1'b1;
					next_s.flags = 7'h02;
				end else if (pin_low || MISSING_CLOCK_REQ_I) begin
					// Level sources keep the hold reloaded
					next_s.hold_cnt = HOLD_W'(INT_HOLD_CYCLES);
				end else if (s.hold_cnt == '0) begin
					next_s.rst_state = WDRST_RUN;
				end else begin
					next_s.hold_cnt = s.hold_cnt - HOLD_W'(1);
				end
			end
		endcase

		// Defaults applied during every reset
		if (s.rst_state != WDRST_RUN || next_s.rst_state != WDRST_RUN) begin
			next_s.wd_en = 1'b1;
			next_s.wd_lock = 1'b0;
			next_s.interval = WDOG_INTERVAL_RST;
			next_s.disarm_win = 3'h0;
			next_s.cnv_en = 1'b0;
			next_s.cmp_en = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign RST_PIN_O      = 1'b0;
	assign RST_PIN_OE_N_O = !s.pin_drive;
	assign SFR_RDATA_O    = s.rdata;
	assign SYS_RESET_N_O  = s.sys_run;
	assign WDOG_ACTIVE_O  = s.wd_en && s.sys_run;

endmodule

// >>> tb/wdrst_checker.sv
// Port checks for the watchdog and reset-source top level
`timescale 1ns/1ps
module wdrst_checker
	import wdrst_pkg::*;
#(
	parameter int POR_HOLD_COUNT = POR_HOLD_CYCLES,
	parameter int WDOG_CNT_W     = WDOG_COUNTER_W
)(
	input wire logic       CLK_I,
	input wire logic       RESET_N_I,
	input wire logic       VDD_OK_I,
	input wire logic       RST_PIN_I,
	input wire logic       RST_PIN_OE_N_O,
	input wire logic       MISSING_CLOCK_REQ_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic       SFR_WE_I,
	input wire logic       SFR_RE_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic       SYS_RESET_N_O,
	input wire logic       WDOG_ACTIVE_O
);
	logic        locked;
	logic [31:0] hold_cnt;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			locked   <= 1'b0;
			hold_cnt <= 32'h0;
		end else begin
			if (!SYS_RESET_N_O)
				locked <= 1'b0;
			else if (SFR_WE_I && SFR_ADDR_I == WDOG_CTRL_ADDR &&
				SFR_WDATA_I == WDOG_CODE_LOCK)
				locked <= 1'b1;
			if (RST_PIN_OE_N_O || !VDD_OK_I)
				hold_cnt <= 32'h0;
			else
				hold_cnt <= hold_cnt + 32'h1;
		end
	end

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);

	a_hold_then_run: assert property (
		$rose(RST_PIN_OE_N_O) |=> SYS_RESET_N_O) else $error("late run");
	a_por_hold_len: assert property (
		$rose(RST_PIN_OE_N_O) |-> hold_cnt >= POR_HOLD_COUNT - 2 &&
		hold_cnt <= POR_HOLD_COUNT + 2) else $error("pin hold length");
	a_pin_only_rst: assert property (
		!RST_PIN_OE_N_O |-> !SYS_RESET_N_O) else $error("pin out of reset");
	a_vdd_loss: assert property (
		!VDD_OK_I |-> ##[1:2] (!RST_PIN_OE_N_O && !SYS_RESET_N_O))
		else $error("supply loss");
	a_pin_request: assert property (
		$fell(RST_PIN_I) && RST_PIN_OE_N_O |=> !SYS_RESET_N_O)
		else $error("pin reset missed");
	a_clock_loss: assert property (
		MISSING_CLOCK_REQ_I |=> !SYS_RESET_N_O) else $error("clock loss");
	a_reset_min_len: assert property (
		$fell(SYS_RESET_N_O) |-> !SYS_RESET_N_O [*8]) else $error("short");
	a_wd_restarts: assert property (
		$rose(SYS_RESET_N_O) |-> ##[0:2] WDOG_ACTIVE_O) else $error("wd off");
	a_read_layout: assert property (
		SFR_RE_I && SFR_ADDR_I == WDOG_CTRL_ADDR |->
		##2 (SFR_RDATA_O[7:5] == 3'h0 && !SFR_RDATA_O[3]))
		else $error("ctrl read layout");
	a_lock_holds: assert property (
		locked && WDOG_ACTIVE_O && SYS_RESET_N_O |=>
		WDOG_ACTIVE_O || !SYS_RESET_N_O) else $error("locked disable");
endmodule

bind wdrst_top wdrst_checker #(
	.POR_HOLD_COUNT(POR_HOLD_COUNT), .WDOG_CNT_W(WDOG_CNT_W)
) u_chk (
	.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .VDD_OK_I(VDD_OK_I),
	.RST_PIN_I(RST_PIN_I), .RST_PIN_OE_N_O(RST_PIN_OE_N_O),
	.MISSING_CLOCK_REQ_I(MISSING_CLOCK_REQ_I), .SFR_ADDR_I(SFR_ADDR_I),
	.SFR_WE_I(SFR_WE_I), .SFR_RE_I(SFR_RE_I), .SFR_WDATA_I(SFR_WDATA_I),
	.SFR_RDATA_O(SFR_RDATA_O), .SYS_RESET_N_O(SYS_RESET_N_O),
	.WDOG_ACTIVE_O(WDOG_ACTIVE_O)
);

// >>> tb/wdrst_bench.sv
// Self-checking bench for the watchdog and reset-source block
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module wdrst_bench;
	import wdrst_pkg::*;
	localparam logic [7:0] EN [7]  = '{8'h10, 8'h00, 8'h00, 8'h40, 8'h20,
		8'h02, 8'h00};
	localparam logic [4:0] DRV [7] = '{5'h17, 5'h07, 5'h1F, 5'h13, 5'h15,
		5'h17, 5'h16};
	localparam logic [7:0] FLG [7] = '{8'h10, 8'h01, 8'h04, 8'h40, 8'h20,
		8'h02, 8'h02};
	localparam logic       PIN [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
		1'b1};
	logic       clk, rst_n, vdd_ok, pin_ext, cnv_n, cmp_o, mcd, tap, we, re;
	logic       saw_pin;
	logic [7:0] addr, wdata;
	wire logic  pin_w, oe_n, sys_n, wd_act, pin_o;
	wire logic  [7:0] rdata;
	int         n_mismatch, checks_done, cycles, n;

	assign pin_w = pin_ext & oe_n;
	always #50 clk = ~clk;

	wdrst_top #(.POR_HOLD_COUNT(32)) uut (
		.CLK_I(clk), .RESET_N_I(rst_n), .VDD_OK_I(vdd_ok), .RST_PIN_I(pin_w),
		.RST_PIN_O(pin_o), .RST_PIN_OE_N_O(oe_n),
		.CONVERT_START_INPUT_N_I(cnv_n),
		.COMPARATOR_OUT_I(cmp_o), .MISSING_CLOCK_REQ_I(mcd),
		.TEST_PORT_RESET_I(tap), .SFR_ADDR_I(addr), .SFR_WE_I(we),
		.SFR_RE_I(re), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
		.SYS_RESET_N_O(sys_n), .WDOG_ACTIVE_O(wd_act));

	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		we    = 1'b1;
		addr  = a;
		wdata = d;
	endtask

	task automatic idle(input int k);
		@(negedge clk);
		we = 1'b0;
		repeat (k - 1) @(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		we   = 1'b0;
		re   = 1'b1;
		addr = a;
		@(negedge clk);
		re = 1'b0;
		@(negedge clk);
		`CHK(rdata, e);
	endtask

	task automatic wait_sys(input logic lvl, output int k);
		k = 0;
		while (sys_n !== lvl && k < 3000) begin
			@(negedge clk);
			k++;
			if (oe_n === 1'b0)
				saw_pin = 1'b1;
		end
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			$display("timeout");
			stop_test();
		end
	end

	initial begin
		{clk, rst_n, mcd, tap, we, re, saw_pin} = 7'h0;
		{vdd_ok, pin_ext, cnv_n, cmp_o} = 4'hF;
		{addr, wdata} = 16'h0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		wait_sys(1'b1, n);
		`CHK(saw_pin, 1'b1);
		`CHK(pin_o, 1'b0);
		rd(RESET_CAUSE_ADDR, 8'h02);
		rd(WDOG_CTRL_ADDR, 8'h17);
		rd(8'h5A, 8'h00);
		wr(WDOG_CTRL_ADDR, 8'h05);
		rd(WDOG_CTRL_ADDR, 8'h15);
		$display("test power-on done");
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM1);
		idle(4);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM2);
		rd(WDOG_CTRL_ADDR, 8'h15);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM1);
		idle(3);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM2);
		rd(WDOG_CTRL_ADDR, 8'h05);
		`CHK(wd_act, 1'b0);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_LOCK);
		rd(WDOG_CTRL_ADDR, 8'h05);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_ENABLE);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM1);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM2);
		rd(WDOG_CTRL_ADDR, 8'h15);
		$display("test disable and lock done");
		wr(WDOG_CTRL_ADDR, 8'h00);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_ENABLE);
		idle(1);
		saw_pin = 1'b0;
		wait_sys(1'b0, n);
		`CHK(n >= 64 && n <= 66, 1'b1);
		wait_sys(1'b1, n);
		`CHK(saw_pin, 1'b0);
		rd(RESET_CAUSE_ADDR, 8'h08);
		rd(WDOG_CTRL_ADDR, 8'h17);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM1);
		wr(WDOG_CTRL_ADDR, WDOG_CODE_DISARM2);
		rd(WDOG_CTRL_ADDR, 8'h07);
		$display("test watchdog timeout done");
		for (int i = 0; i < 7; i++) begin
			saw_pin = 1'b0;
			if (EN[i] != 8'h00)
				wr(RESET_CAUSE_ADDR, EN[i]);
			idle(2);
			{pin_ext, mcd, cnv_n, cmp_o, vdd_ok} = DRV[i];
			idle(3);
			{pin_ext, mcd, cnv_n, cmp_o, vdd_ok} = 5'h17;
			wait_sys(1'b0, n);
			wait_sys(1'b1, n);
			`CHK(saw_pin, PIN[i]);
			rd(RESET_CAUSE_ADDR, FLG[i]);
		end
		$display("test reset sources done");
		tap = 1'b1;
		rd(RESET_CAUSE_ADDR, 8'h82);
		tap = 1'b0;
		rd(RESET_CAUSE_ADDR, 8'h02);
		$display("test port flag done");
		stop_test();
	end
endmodule
